// [wave_table_defines.svh]
`ifndef WAVE_TABLE_DEFINES_SVH
`define WAVE_TABLE_DEFINES_SVH

// Register indices; byte address is four times the index
`define WT_IDX_LOW        8'h60
`define WT_IDX_MID        8'h61
`define WT_IDX_UPPER      8'h62
`define WT_IDX_STATUS     8'h6F

// Reset values of the delta words
`define WT_RST_LOW        32'hAAAAB554
`define WT_RST_MID        32'h4A9554AA
`define WT_RST_UPPER      32'h24492929

// Last entry held by this bank
`define WT_LAST_ENTRY     7'h5F

// Status word field positions
`define ST_COIL_A_LSB     0
`define ST_COIL_B_LSB     8
`define ST_POS_LSB        16
`define ST_DONE_BIT       24

`endif

// [wave_table_pkg.sv]
`default_nettype none
package wave_table_pkg;

    // Segment width selectors and segment boundaries
    typedef struct packed {
        logic [1:0] w3;
        logic [1:0] w2;
        logic [1:0] w1;
        logic [1:0] w0;
        logic [7:0] x3;
        logic [7:0] x2;
        logic [7:0] x1;
    } seg_cfg_t;

    typedef enum logic [2:0] {
        WK_IDLE = 3'b001,
        WK_RUN  = 3'b010,
        WK_END  = 3'b100
    } walk_state_t;

    // Whole state of the table block
    typedef struct packed {
        logic [31:0] word_low;
        logic [31:0] word_mid;
        logic [31:0] word_upper;
        logic [31:0] prdata;
        logic        pslverr;
        walk_state_t walk;
        logic [6:0]  pos;
        logic [7:0]  coil_a;
        logic [7:0]  coil_b;
    } state_t;

endpackage
`default_nettype wire

// [wave_table_lower.sv]
// The APB interface to the registers was decided locally.
`default_nettype none
`include "wave_table_defines.svh"

module wave_table_lower
    import wave_table_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Segment configuration and start values
    input  wire seg_cfg_t    seg_cfg,
    input  wire logic [7:0]  sine_start_value,
    input  wire logic [7:0]  cosine_start_value,
    // Indexer handshake
    input  wire logic        counter_zero,
    input  wire logic        step_advance,
    // Walker results
    output logic      [7:0]  coil_a_current,
    output logic      [7:0]  coil_b_current,
    output logic      [6:0]  table_pos,
    output logic             walk_done
);

    state_t st_reg;
    state_t st_next;

    // Register decode: 0 none, 1 low, 2 mid, 3 upper, 4 status
    function automatic logic [2:0] reg_sel(input logic [11:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        if (addr[1:0] == 2'h0) begin
            unique case (addr[9:2])
                `WT_IDX_LOW:    sel = 3'h1;
                `WT_IDX_MID:    sel = 3'h2;
                `WT_IDX_UPPER:  sel = 3'h3;
                `WT_IDX_STATUS: sel = 3'h4;
                default:        sel = 3'h0;
            endcase
        end
        if (addr[11:10] != 2'h0) begin
            sel = 3'h0;
        end
        return sel;
    endfunction

    // Width selector of the segment holding an entry
    function automatic logic [1:0] seg_width(input logic [6:0] p,
                                             input seg_cfg_t  c);
        logic [7:0] pe;
        pe = {1'b0, p};
        if (pe < c.x1) begin
            return c.w0;
        end else if (pe < c.x2) begin
            return c.w1;
        end else if (pe < c.x3) begin
            return c.w2;
        end else begin
            return c.w3;
        end
    endfunction

    logic [95:0] table_bits;
    logic        delta_bit;
    logic [1:0]  width;
    logic [9:0]  sum;
    logic [7:0]  stepped;
    logic [2:0]  setup_sel;
    logic [2:0]  access_sel;
    logic [31:0] status_word;

    // Bit n of each word is entry n of its group, low word first
    assign table_bits = {st_reg.word_upper, st_reg.word_mid,
                         st_reg.word_low};
    assign delta_bit  = table_bits[st_reg.pos];
    assign width      = seg_width(st_reg.pos, seg_cfg);

    // Step is width plus delta minus one; clamped to the 8-bit range
    assign sum = {2'h0, st_reg.coil_a} + {8'h00, width}
               + {9'h000, delta_bit} - 10'h001;
    assign stepped = sum[9] ? 8'h00 : (sum[8] ? 8'hFF : sum[7:0]);

    assign setup_sel  = reg_sel(paddr);
    assign access_sel = setup_sel;

    // Walker state seen by software
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`ST_COIL_A_LSB +: 8] = st_reg.coil_a;
        status_word[`ST_COIL_B_LSB +: 8] = st_reg.coil_b;
        status_word[`ST_POS_LSB +: 7]    = st_reg.pos;
        status_word[`ST_DONE_BIT]        = (st_reg.walk == WK_END);
    end

    // Next state: bus slave and table walker
    always_comb begin
        st_next = st_reg;
        // Read data is fetched in setup so it is steady in access
        if (psel && !penable) begin
            st_next.pslverr = (setup_sel == 3'h0)
                            || (pwrite && setup_sel == 3'h4);
            unique case (setup_sel)
                3'h1:    st_next.prdata = st_reg.word_low;
                3'h2:    st_next.prdata = st_reg.word_mid;
                3'h3:    st_next.prdata = st_reg.word_upper;
                3'h4:    st_next.prdata = status_word;
                default: st_next.prdata = 32'h0000_0000;
            endcase
        end
        // Writes land in the access cycle; status is read only
        if (psel && penable && pwrite) begin
            unique case (access_sel)
                3'h1:    st_next.word_low   = pwdata;
                3'h2:    st_next.word_mid   = pwdata;
                3'h3:    st_next.word_upper = pwdata;
                default: st_next.word_low   = st_reg.word_low;
            endcase
        end
        // Restart wins over a step arriving in the same cycle
        if (counter_zero) begin
            st_next.coil_a = sine_start_value;
            st_next.coil_b = cosine_start_value;
            st_next.pos    = 7'h00;
            st_next.walk   = WK_RUN;
        end else if (step_advance) begin
            unique case (st_reg.walk)
                WK_RUN: begin
                    st_next.coil_a = stepped;
                    // Quarter ends at the last entry; later quarters
                    // are built elsewhere from this one
                    if (st_reg.pos == `WT_LAST_ENTRY) begin
                        st_next.walk = WK_END;
                    end else begin
                        st_next.pos = st_reg.pos + 7'h01;
                    end
                end
                WK_IDLE, WK_END: begin
                    st_next.walk = st_reg.walk;
                end
            endcase
        end
    end

    // State register with default sine table at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.word_low   <= `WT_RST_LOW;
            st_reg.word_mid   <= `WT_RST_MID;
            st_reg.word_upper <= `WT_RST_UPPER;
            st_reg.prdata     <= 32'h0000_0000;
            st_reg.pslverr    <= 1'b0;
            st_reg.walk       <= WK_IDLE;
            st_reg.pos        <= 7'h00;
            st_reg.coil_a     <= 8'h00;
            st_reg.coil_b     <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // Zero wait states; answers always come from flip-flops
    assign pready         = 1'b1;
    assign prdata         = st_reg.prdata;
    assign pslverr        = st_reg.pslverr;
    assign coil_a_current = st_reg.coil_a;
    assign coil_b_current = st_reg.coil_b;
    assign table_pos      = st_reg.pos;
    assign walk_done      = (st_reg.walk == WK_END);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_write_low_word: assert property (
        psel && penable && pwrite && access_sel == 3'h1
        |=> st_reg.word_low == $past(pwdata))
        else $error("low word not written");

    a_write_mid_word: assert property (
        psel && penable && pwrite && access_sel == 3'h2
        |=> st_reg.word_mid == $past(pwdata))
        else $error("mid word not written");

    a_write_upper_word: assert property (
        psel && penable && pwrite && access_sel == 3'h3
        |=> st_reg.word_upper == $past(pwdata))
        else $error("upper word not written");

    a_read_back_low: assert property (
        psel && !penable && !pwrite && setup_sel == 3'h1
        |=> prdata == st_reg.word_low && !pslverr)
        else $error("low word read back wrong");

    a_restart_load: assert property (
        counter_zero
        |=> coil_a_current == $past(sine_start_value)
            && coil_b_current == $past(cosine_start_value)
            && table_pos == 7'h00 && !walk_done)
        else $error("start values not loaded");

    a_step_down_one: assert property (
        !counter_zero && step_advance && st_reg.walk == WK_RUN
        && !delta_bit && width == 2'h0 && st_reg.coil_a != 8'h00
        |=> coil_a_current == $past(st_reg.coil_a) - 8'h01)
        else $error("zero delta step wrong");

    // Zero delta in a flat segment leaves the current alone
    a_step_flat: assert property (
        !counter_zero && step_advance && st_reg.walk == WK_RUN
        && !delta_bit && width == 2'h1
        |=> coil_a_current == $past(st_reg.coil_a))
        else $error("zero delta flat step wrong");

    a_step_up_two: assert property (
        !counter_zero && step_advance && st_reg.walk == WK_RUN
        && !delta_bit && width == 2'h3 && st_reg.coil_a < 8'hFE
        |=> coil_a_current == $past(st_reg.coil_a) + 8'h02)
        else $error("zero delta steep step wrong");

    a_step_hold_zero: assert property (
        !counter_zero && step_advance && st_reg.walk == WK_RUN
        && delta_bit && width == 2'h0
        |=> coil_a_current == $past(st_reg.coil_a))
        else $error("one delta flat step wrong");

    a_step_up_three: assert property (
        !counter_zero && step_advance && st_reg.walk == WK_RUN
        && delta_bit && width == 2'h3 && st_reg.coil_a < 8'hFD
        |=> coil_a_current == $past(st_reg.coil_a) + 8'h03)
        else $error("one delta step wrong");

    a_first_bit: assert property (
        !counter_zero && step_advance && st_reg.walk == WK_RUN
        && table_pos == 7'h00 && width == 2'h1 && st_reg.coil_a != 8'hFF
        |=> coil_a_current == $past(st_reg.coil_a)
            + {7'h00, $past(st_reg.word_low[0])})
        else $error("entry 0 not from bit 0");

    a_pos_in_quarter: assert property (
        table_pos <= `WT_LAST_ENTRY)
        else $error("position past quarter");

    // Each step moves one entry on until the last one of the quarter
    a_pos_advance: assert property (
        !counter_zero && step_advance && st_reg.walk == WK_RUN
        && table_pos != `WT_LAST_ENTRY
        |=> table_pos == $past(table_pos) + 7'h01)
        else $error("position did not advance");

    a_quarter_end: assert property (
        !counter_zero && step_advance && st_reg.walk == WK_RUN
        && table_pos == `WT_LAST_ENTRY
        |=> walk_done && table_pos == `WT_LAST_ENTRY)
        else $error("quarter end not flagged");

    // Steps outside a walk must not move anything
    a_idle_step_ignored: assert property (
        !counter_zero && step_advance && st_reg.walk != WK_RUN
        |=> coil_a_current == $past(coil_a_current)
            && table_pos == $past(table_pos))
        else $error("step taken outside a walk");

    a_coil_b_held: assert property (
        !counter_zero
        |=> coil_b_current == $past(coil_b_current))
        else $error("cosine value moved without restart");

    a_unmapped_error: assert property (
        psel && !penable && setup_sel == 3'h0
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    a_read_back_mid: assert property (
        psel && !penable && !pwrite && setup_sel == 3'h2
        |=> prdata == st_reg.word_mid && !pslverr)
        else $error("mid word read back wrong");

    a_read_back_upper: assert property (
        psel && !penable && !pwrite && setup_sel == 3'h3
        |=> prdata == st_reg.word_upper && !pslverr)
        else $error("upper word read back wrong");

    // Status is read only: refused, and no word may change
    a_status_read_only: assert property (
        psel && penable && pwrite && access_sel == 3'h4
        |-> pslverr ##1 (st_reg.word_low == $past(st_reg.word_low)
            && st_reg.word_mid == $past(st_reg.word_mid)
            && st_reg.word_upper == $past(st_reg.word_upper)))
        else $error("status write not refused");

    // Read data and error stand until the next setup cycle
    a_answer_stands: assert property (
        psel && penable
        |=> prdata == $past(prdata) && pslverr == $past(pslverr))
        else $error("answer changed after access");

endmodule // wave_table_lower
`default_nettype wire

// [wave_table_lower_tb.sv]
`default_nettype none
module wave_table_lower_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wave_table_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr;
    seg_cfg_t    seg_cfg = '0;
    logic [7:0]  sine_start_value = 8'h14, cosine_start_value = 8'h3C;
    logic        counter_zero = 1'b0, step_advance = 1'b0;
    logic [7:0]  coil_a_current, coil_b_current;
    logic [6:0]  table_pos;
    logic        walk_done;
    int          errors = 0, n_compared = 0;
    logic [31:0] wt [3] = '{32'hAAAAB554, 32'h4A9554AA, 32'h24492929};
    logic [31:0] rd;
    logic        er;

    wave_table_lower wave_table_lower_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seg_cfg(seg_cfg),
        .sine_start_value(sine_start_value),
        .cosine_start_value(cosine_start_value),
        .counter_zero(counter_zero), .step_advance(step_advance),
        .coil_a_current(coil_a_current), .coil_b_current(coil_b_current),
        .table_pos(table_pos), .walk_done(walk_done));

    // Free-running bus clock
    always #5 pclk = ~pclk;

    task automatic complete_run;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the wait on pready is bounded so a hang ends the run
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One cycle pulse on the indexer inputs, outputs checked after it lands
    task automatic pulse(input logic zero);
        @(posedge pclk);
        counter_zero <= zero;
        step_advance <= !zero;
        @(posedge pclk);
        counter_zero <= 1'b0;
        step_advance <= 1'b0;
        #1;
    endtask

    // Reset words, mapping and full-width write and read back
    task automatic regs_scn;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'h180 + 12'(4 * i), 32'h0);
            chk(rd, wt[i]);
            chk({31'h0, er}, 32'h0);
        end
        pulse(1'b0);
        chk({24'h0, coil_a_current}, 32'h0);
        apb(1'b1, 12'h184, 32'h5A5AC3C3);
        apb(1'b1, 12'h188, 32'hFFFF0001);
        apb(1'b0, 12'h184, 32'h0);
        chk(rd, 32'h5A5AC3C3);
        apb(1'b0, 12'h188, 32'h0);
        chk(rd, 32'hFFFF0001);
        apb(1'b0, 12'h190, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 12'h1BC, 32'h1);
        chk({31'h0, er}, 32'h1);
        wt[1] = 32'h5A5AC3C3;
        wt[2] = 32'hFFFF0001;
    endtask

    // Full quarter walk against a model of the step coding
    task automatic walk_scn(input int w_first);
        int a;
        int bt;
        int w;
        seg_cfg <= '{w3: 2'b11, w2: 2'b10, w1: 2'b01, w0: 2'(w_first),
                     x3: 8'h30, x2: 8'h18, x1: 8'h08};
        pulse(1'b1);
        a = 20;
        chk({24'h0, coil_a_current}, 32'h14);
        chk({24'h0, coil_b_current}, 32'h3C);
        chk({25'h0, table_pos}, 32'h0);
        for (int p = 0; p < 96; p++) begin
            bt = wt[p / 32][p % 32];
            w = p < 8 ? w_first : p < 24 ? 1 : p < 48 ? 2 : 3;
            a = a + w + bt - 1;
            a = a < 0 ? 0 : a > 255 ? 255 : a;
            pulse(1'b0);
            chk({24'h0, coil_a_current}, 32'(a));
            chk({25'h0, table_pos}, 32'(p < 95 ? p + 1 : 95));
        end
        chk({31'h0, walk_done}, 32'h1);
        pulse(1'b0);
        chk({24'h0, coil_a_current}, 32'(a));
        apb(1'b0, 12'h1BC, 32'h0);
        chk(rd, {7'h0, 1'b1, 1'b0, 7'h5F, 8'h3C, 8'(a)});
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        regs_scn();
        walk_scn(0);
        apb(1'b1, 12'h180, 32'h0F0F0F0F);
        wt[0] = 32'h0F0F0F0F;
        walk_scn(1);
        complete_run();
    end
endmodule // wave_table_lower_tb
`default_nettype wire
